// ===== rtl/spf_framer.sv
/*
 * spf_framer: builds 2048-byte scan-profile and info-telegram blocks as a byte stream.
 * assumes the sink takes a byte when out_valid and out_ready are high, and that
 * sources (header, profile, registers, firmware, fifo) answer same-cycle by index.
 */
// Overview of operation
// - every block is exactly 2048 bytes
// - byte 60 holds version, profile default 3
// - version 0x10 for info, 0x11 on fault
// - scan data section starts at byte 66
// - length byte precedes function and status registers in profile blocks
// - eight zeros, version, four encoder bytes
// - encoder data sent in every profile block
// - last three bytes hold fifo fill status
// - command 0x21 sends one info block
// - info carries registers 0-63, no profile
// - info telegram version byte is 0x10
// - info sync raster is eight zero bytes
// - status regs at 66, eeprom at 98
// - firmware string from 130, 0x00 terminated
// - 31 function register bytes follow string
// - info 0xff fill follows function registers
// - 0xff fill precedes the fifo status
`timescale 1ns/100ps
module spf_framer
	import spf_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        profile_start,
	input  wire logic        profile_fault,
	input  wire logic [10:0] profile_len,
	input  wire logic [7:0]  profile_byte,
	input  wire logic [7:0]  header_byte,
	input  wire logic [7:0]  encoder_byte,
	input  wire logic [7:0]  reg_byte,
	input  wire logic [7:0]  func_byte,
	input  wire logic [7:0]  fw_byte,
	input  wire logic [7:0]  fifo_byte,
	input  wire logic [7:0]  status1,
	input  wire logic [7:0]  status2,
	input  wire logic [7:0]  image_nr,
	input  wire logic        out_ready,
	output logic             out_valid,
	output logic [7:0]       out_data,
	output logic             out_first,
	output logic             out_last,
	output logic [10:0]      src_index,
	output logic [5:0]       reg_index,
	output logic             busy
);
	// ==========================================================
	// reset release
	logic rst_n;
	spf_reset_sync spf_reset_sync_i (
		.clock      (clock),
		.reset_n    (reset_n),
		.rst_n_sync (rst_n)
	);

	// ==========================================================
	// pending info request: set wins over the clear on block start
	logic info_pend_q, info_pend_d;
	logic prof_pend_q, prof_pend_d;
	logic fault_pend_q, fault_pend_d;
	spf_state_t state_q, state_d;
	logic       info_q, info_d;
	logic       fault_q, fault_d;
	logic [10:0] pos_q, pos_d;
	logic [10:0] plen_q, plen_d;
	logic [10:0] sub_q, sub_d;
	logic        valid_q, valid_d;
	logic [7:0]  data_q, data_d;
	logic        first_q, first_d;
	logic        last_q, last_d;
	logic        take;
	logic        start_blk;

	assign take = valid_q && out_ready;
	assign start_blk = (state_q == SPF_IDLE) && !valid_q && (info_pend_q || prof_pend_q);

	always_comb begin
		info_pend_d  = info_pend_q;
		prof_pend_d  = prof_pend_q;
		fault_pend_d = fault_pend_q;
		if (start_blk && info_pend_q)
			info_pend_d = 1'b0;
		else if (start_blk)
			prof_pend_d = 1'b0;
		if (cmd_valid && cmd_code == CMD_INFO)
			info_pend_d = 1'b1;
		if (profile_start) begin
			prof_pend_d  = 1'b1;
			fault_pend_d = profile_fault;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			info_pend_q  <= 1'b0;
			prof_pend_q  <= 1'b0;
			fault_pend_q <= 1'b0;
		end else begin
			info_pend_q  <= info_pend_d;
			prof_pend_q  <= prof_pend_d;
			fault_pend_q <= fault_pend_d;
		end
	end

	// ==========================================================
	// byte sequencer
	function automatic logic [5:0] sub_lo(input logic [10:0] s);
		return s[5:0];
	endfunction

	always_comb begin
		logic adv;
		adv      = !valid_q || take;
		state_d  = state_q;
		info_d   = info_q;
		fault_d  = fault_q;
		pos_d    = pos_q;
		plen_d   = plen_q;
		sub_d    = sub_q;
		valid_d  = valid_q && !take;
		data_d   = data_q;
		first_d  = first_q && !take;
		last_d   = last_q && !take;
		if (start_blk) begin
			state_d = SPF_HDR;
			info_d  = info_pend_q;
			fault_d = fault_pend_q;
			plen_d  = profile_len;
			pos_d   = 11'h000;
			sub_d   = 11'h000;
		end else if (adv && state_q != SPF_IDLE) begin
			valid_d = 1'b1;
			first_d = (pos_q == 11'h000);
			last_d  = (pos_q == OFS_LAST);
			pos_d   = pos_q + 11'h001;
			sub_d   = sub_q + 11'h001;
			data_d  = FILL_BYTE;
			unique case (state_q)
				SPF_HDR: begin
					if (pos_q >= OFS_RASTER && pos_q < OFS_VERSION)
						data_d = 8'h00;
					else if (pos_q == OFS_VERSION)
						data_d = info_q ? VER_INFO : (fault_q ? VER_FAULT : VER_PROFILE);
					else if (pos_q == OFS_STATUS1)
						data_d = status1;
					else if (pos_q == OFS_IMAGE)
						data_d = image_nr;
					else if (pos_q == OFS_STATUS2)
						data_d = status2;
					else if (pos_q > OFS_STATUS2)
						data_d = 8'h00;
					else
						data_d = header_byte;
					if (pos_q == OFS_DATA - 11'h001) begin
						sub_d   = 11'h000;
						state_d = info_q ? SPF_SREG : (plen_q == 11'h000 ? SPF_ZERO : SPF_PROF);
					end
				end
				SPF_PROF: begin
					data_d = profile_byte;
					if (sub_q == plen_q - 11'h001) begin
						sub_d   = 11'h000;
						state_d = SPF_ZERO;
					end
				end
				SPF_ZERO: begin
					data_d = 8'h00;
					if (sub_lo(sub_q) == RASTER_LEN - 6'h01) begin
						sub_d   = 11'h000;
						state_d = SPF_PVER;
					end
				end
				SPF_PVER: begin
					data_d  = fault_q ? VER_FAULT : VER_PROFILE;
					sub_d   = 11'h000;
					state_d = SPF_ENC;
				end
				SPF_ENC: begin
					data_d = encoder_byte;
					if (sub_lo(sub_q) == ENC_LEN - 6'h01) begin
						sub_d   = 11'h000;
						state_d = SPF_FLEN;
					end
				end
				SPF_FLEN: begin
					data_d  = {2'b00, FUNC_REGS};
					sub_d   = 11'h000;
					state_d = SPF_FREG;
				end
				SPF_FREG: begin
					data_d = func_byte;
					if (sub_lo(sub_q) == FUNC_REGS - 6'h01) begin
						sub_d   = 11'h000;
						state_d = info_q ? SPF_FILL : SPF_SLEN;
					end
				end
				SPF_SLEN: begin
					data_d  = {2'b00, STAT_COUNT};
					sub_d   = 11'h000;
					state_d = SPF_SREG;
				end
				SPF_SREG: begin
					data_d = reg_byte;
					if (info_q && pos_q == OFS_FW - 11'h001) begin
						sub_d   = 11'h000;
						state_d = SPF_FWSTR;
					end else if (!info_q && sub_lo(sub_q) == STAT_COUNT - 6'h01) begin
						state_d = SPF_FILL;
					end
				end
				SPF_FWSTR: begin
					data_d = (sub_lo(sub_q) == FW_MAX - 6'h01) ? 8'h00 : fw_byte;
					if (data_d == 8'h00) begin
						sub_d   = 11'h000;
						state_d = SPF_FREG;
					end
				end
				SPF_FILL: begin
					data_d = FILL_BYTE;
					if (pos_q == OFS_FIFO - 11'h001) begin
						sub_d   = 11'h000;
						state_d = SPF_FIFO;
					end
				end
				SPF_FIFO: begin
					data_d = fifo_byte;
					if (pos_q == OFS_LAST)
						state_d = SPF_IDLE;
				end
				default: begin
					state_d = SPF_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SPF_IDLE;
			info_q  <= 1'b0;
			fault_q <= 1'b0;
			pos_q   <= 11'h000;
			plen_q  <= 11'h000;
			sub_q   <= 11'h000;
			valid_q <= 1'b0;
			data_q  <= 8'h00;
			first_q <= 1'b0;
			last_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			info_q  <= info_d;
			fault_q <= fault_d;
			pos_q   <= pos_d;
			plen_q  <= plen_d;
			sub_q   <= sub_d;
			valid_q <= valid_d;
			data_q  <= data_d;
			first_q <= first_d;
			last_q  <= last_d;
		end
	end

	// ==========================================================
	// outputs; index ports are flop copies so the sources see a settled index all cycle
	logic [5:0]  ridx_q;
	logic        busy_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ridx_q <= 6'h00;
			busy_q <= 1'b0;
		end else begin
			ridx_q <= sub_d[5:0];
			busy_q <= (state_d != SPF_IDLE);
		end
	end
	assign src_index = sub_q;
	assign reg_index = ridx_q;
	assign out_valid = valid_q;
	assign out_data  = data_q;
	assign out_first = first_q;
	assign out_last  = last_q;
	assign busy      = busy_q;

	// ==========================================================
	// checks
	logic [11:0] blk_cnt_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			blk_cnt_q <= 12'h000;
		else if (take)
			blk_cnt_q <= out_last ? 12'h000 : blk_cnt_q + 12'h001;
	end

	a_block_length: assert property (@(posedge clock) disable iff (!rst_n)
		take && out_last |-> blk_cnt_q == 12'h7ff)
		else $error("block not 2048 bytes");
	a_info_version: assert property (@(posedge clock) disable iff (!rst_n)
		take && blk_cnt_q == 12'h03c && info_q |-> out_data == VER_INFO)
		else $error("info version byte wrong");
	a_profile_version: assert property (@(posedge clock) disable iff (!rst_n)
		take && blk_cnt_q == 12'h03c && !info_q && !fault_q |-> out_data == VER_PROFILE)
		else $error("profile version byte wrong");
	a_fault_version: assert property (@(posedge clock) disable iff (!rst_n)
		take && blk_cnt_q == 12'h03c && !info_q && fault_q |-> out_data == VER_FAULT)
		else $error("fault version byte wrong");
	a_raster_zero: assert property (@(posedge clock) disable iff (!rst_n)
		take && blk_cnt_q >= 12'h034 && blk_cnt_q < 12'h03c |-> out_data == 8'h00)
		else $error("sync raster not zero");
	a_info_request: assert property (@(posedge clock) disable iff (!rst_n)
		cmd_valid && cmd_code == CMD_INFO |=> info_pend_q || info_q)
		else $error("info request lost");
	a_fifo_tail: assert property (@(posedge clock) disable iff (!rst_n)
		take && blk_cnt_q >= 12'h7fd |-> state_q == SPF_FIFO || state_q == SPF_IDLE)
		else $error("fifo status not at block end");
	a_first_flag: assert property (@(posedge clock) disable iff (!rst_n)
		take && out_first |-> blk_cnt_q == 12'h000)
		else $error("first flag misplaced");
endmodule

// ===== pkg/spf_pkg.sv
/*
 * spf_pkg: constants shared by the scan packet framer.
 * assumes a byte-wide stream sink and byte-wide profile/register sources on one 25 MHz clock.
 */
package spf_pkg;
	localparam int unsigned BLOCK_BYTES  = 2048;
	localparam logic [10:0] OFS_LAST     = 11'h7ff;
	localparam logic [10:0] OFS_RASTER   = 11'h034;
	localparam logic [10:0] OFS_VERSION  = 11'h03c;
	localparam logic [10:0] OFS_STATUS1  = 11'h03d;
	localparam logic [10:0] OFS_IMAGE    = 11'h03e;
	localparam logic [10:0] OFS_STATUS2  = 11'h03f;
	localparam logic [10:0] OFS_DATA     = 11'h042;
	localparam logic [10:0] OFS_EEPROM   = 11'h062;
	localparam logic [10:0] OFS_FW       = 11'h082;
	localparam logic [10:0] OFS_FIFO     = 11'h7fd;
	localparam logic [7:0]  VER_PROFILE  = 8'h03;
	localparam logic [7:0]  VER_INFO     = 8'h10;
	localparam logic [7:0]  VER_FAULT    = 8'h11;
	localparam logic [7:0]  CMD_INFO     = 8'h21;
	localparam logic [7:0]  FILL_BYTE    = 8'hff;
	localparam logic [5:0]  RASTER_LEN   = 6'h08;
	localparam logic [5:0]  ENC_LEN      = 6'h04;
	localparam logic [5:0]  STAT_REGS    = 6'h20;
	localparam logic [5:0]  FUNC_REGS    = 6'h1f;
	localparam logic [5:0]  FIFO_LEN     = 6'h03;
	localparam logic [5:0]  FW_MAX       = 6'h20;
	localparam logic [5:0]  STAT_COUNT   = 6'h20;
	typedef enum logic [3:0] {
		SPF_IDLE, SPF_HDR, SPF_PROF, SPF_ZERO, SPF_PVER, SPF_ENC, SPF_FLEN, SPF_FREG,
		SPF_SLEN, SPF_SREG, SPF_FWSTR, SPF_FILL, SPF_FIFO
	} spf_state_t;
endpackage

// ===== rtl/spf_reset_sync.sv
/*
 * spf_reset_sync: two-stage release of the asynchronous active-low reset.
 * assumes reset_n may change at any time relative to clock.
 */
`timescale 1ns/100ps
module spf_reset_sync (
	input  wire logic clock,
	input  wire logic reset_n,
	output logic      rst_n_sync
);
	logic stage_q;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage_q    <= 1'b0;
			rst_n_sync <= 1'b0;
		end else begin
			stage_q    <= 1'b1;
			rst_n_sync <= stage_q;
		end
	end
endmodule

// ===== tb/spf_host_model.sv
/*
 spf_host_model: receiving host; stores each 2048-byte block and checks its framing.
 assumes the framer byte stream with a valid/ready handshake on one clock.
*/
`timescale 1ns/100ps
module spf_host_model (
	input  wire logic       clock,
	input  wire logic       reset_n,
	input  wire logic       slow,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_data,
	input  wire logic       out_first,
	input  wire logic       out_last,
	output logic            out_ready,
	output int              blocks,
	output int              frame_errs,
	output logic            is_info
);
	logic [7:0] blk [2048];
	int         pos;
	int         tick = 0;
	// ====
	// stall: a slow host refuses every third cycle
	always @(negedge clock) begin
		tick <= tick + 1;
		out_ready <= !slow || (tick % 3 != 0);
	end
	// ====
	// capture
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pos <= 0;
			blocks <= 0;
			frame_errs <= 0;
			is_info <= 1'b0;
		end else if (out_valid && out_ready) begin
			blk[pos] <= out_data;
			if (out_first !== (pos == 0) || out_last !== (pos == 2047))
				frame_errs <= frame_errs + 1;
			pos <= out_last ? 0 : pos + 1;
			if (out_last)
				blocks <= blocks + 1;
			if (pos == 60)
				is_info <= (out_data == 8'h10);
		end
	end
endmodule

// ===== tb/spf_framer_tb_top.sv
/*
 spf_framer_tb_top: self-checking bench for the framer with a host model.
 assumes sources answer by index; they are re-driven each falling edge.
*/
`timescale 1ns/100ps
module spf_framer_tb_top
	import spf_pkg::*;
;
	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic        cmd_valid = 1'b0;
	logic [7:0]  cmd_code = 8'h00;
	logic        profile_start = 1'b0;
	logic        profile_fault = 1'b0;
	logic [10:0] profile_len = 11'h000;
	logic [7:0]  profile_byte = 8'h00, header_byte = 8'h00, encoder_byte = 8'h00;
	logic [7:0]  reg_byte = 8'h00, func_byte = 8'h00, fw_byte = 8'h00, fifo_byte = 8'h00;
	logic [7:0]  status1 = 8'h61, image_nr = 8'h62, status2 = 8'h63;
	logic        slow = 1'b0;
	logic        out_ready, out_valid, out_first, out_last, busy, is_info;
	logic [7:0]  out_data;
	logic [10:0] src_index;
	logic [5:0]  reg_index;
	int          blocks, frame_errs;
	int          bad_count = 0;
	int          total_checks = 0;

	always #20 clock = ~clock;

	spf_framer spf_framer_i (.clock, .reset_n, .cmd_valid, .cmd_code, .profile_start,
		.profile_fault, .profile_len, .profile_byte, .header_byte, .encoder_byte, .reg_byte,
		.func_byte, .fw_byte, .fifo_byte, .status1, .status2, .image_nr, .out_ready,
		.out_valid, .out_data, .out_first, .out_last, .src_index, .reg_index, .busy);
	spf_host_model spf_host_model_i (.clock, .reset_n, .slow, .out_valid, .out_data,
		.out_first, .out_last, .out_ready, .blocks, .frame_errs, .is_info);

	// ====
	// sources: each byte except the 0x00 firmware terminator encodes its own index so misplacement shows
	always @(negedge clock) begin
		header_byte <= 8'h30 + src_index[7:0];
		profile_byte <= 8'h11 + src_index[7:0];
		encoder_byte <= 8'he0 + src_index[7:0];
		func_byte <= 8'h80 + src_index[7:0];
		fifo_byte <= 8'hc0 + src_index[7:0];
		reg_byte <= 8'h40 + {2'h0, reg_index};
		fw_byte <= (src_index < 11'h003) ? 8'h46 + src_index[7:0] : 8'h00;
	end

	// ====
	// checking helpers
	task automatic tally_and_finish;
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_seq(input int start, input int n, input logic [7:0] base, input bit inc);
		for (int i = 0; i < n; i++)
			check(spf_host_model_i.blk[start + i], base + (inc ? i[7:0] : 8'h00));
	endtask

	// bounded: a stuck framer ends the run instead of hanging it
	task automatic wait_blocks(input int n);
		int k;
		k = 0;
		while (blocks < n && k < 20000) begin
			@(negedge clock);
			k++;
		end
		if (blocks < n) begin
			bad_count++;
			tally_and_finish();
		end
	endtask

	task automatic chk_head(input logic [7:0] ver);
		chk_seq(0, 52, 8'h30, 1'b1);
		chk_seq(52, 8, 8'h00, 1'b0);
		check(spf_host_model_i.blk[60], ver);
		chk_seq(61, 3, 8'h61, 1'b1);
		chk_seq(64, 2, 8'h00, 1'b0);
	endtask

	// ====
	// scenarios
	task automatic run_profile(input logic flt, input int len, input logic [7:0] ver);
		int p;
		p = 66 + len;
		@(negedge clock);
		profile_len <= len[10:0];
		profile_fault <= flt;
		profile_start <= 1'b1;
		@(negedge clock);
		profile_start <= 1'b0;
		wait_blocks(blocks + 1);
		chk_head(ver);
		chk_seq(66, len, 8'h11, 1'b1);
		chk_seq(p, 8, 8'h00, 1'b0);
		check(spf_host_model_i.blk[p + 8], ver);
		chk_seq(p + 9, 4, 8'he0, 1'b1);
		check(spf_host_model_i.blk[p + 13], 8'h1f);
		chk_seq(p + 14, 31, 8'h80, 1'b1);
		check(spf_host_model_i.blk[p + 45], 8'h20);
		chk_seq(p + 46, 32, 8'h40, 1'b1);
		chk_seq(2045, 3, 8'hc0, 1'b1);
		check({7'h00, is_info}, 8'h00);
	endtask

	// an unrelated command just before the info request must not add a block
	task automatic run_info;
		int b;
		b = blocks;
		@(negedge clock);
		cmd_code <= 8'h20;
		cmd_valid <= 1'b1;
		@(negedge clock);
		cmd_code <= CMD_INFO;
		@(negedge clock);
		cmd_valid <= 1'b0;
		@(negedge clock);
		check({7'h00, busy}, 8'h01);
		wait_blocks(b + 1);
		chk_head(VER_INFO);
		chk_seq(66, 64, 8'h40, 1'b1);
		chk_seq(130, 3, 8'h46, 1'b1);
		check(spf_host_model_i.blk[133], 8'h00);
		chk_seq(134, 31, 8'h80, 1'b1);
		chk_seq(165, 1880, FILL_BYTE, 1'b0);
		chk_seq(2045, 3, 8'hc0, 1'b1);
		check({7'h00, is_info}, 8'h01);
		repeat (3000) @(negedge clock);
		check(8'(blocks - b), 8'h01);
		check({7'h00, busy}, 8'h00);
	endtask

	initial begin
		repeat (6) @(negedge clock);
		reset_n <= 1'b1;
		repeat (4) @(negedge clock);
		run_profile(1'b0, 20, VER_PROFILE);
		slow <= 1'b1;
		run_profile(1'b1, 1, VER_FAULT);
		run_info();
		slow <= 1'b0;
		run_profile(1'b0, 1800, VER_PROFILE);
		check(frame_errs[7:0], 8'h00);
		tally_and_finish();
	end
endmodule
